// [design/isr_status.sv]
/*
  Status reporting register bank: operation and questionable groups, each
  with a live condition register, a latched event register cleared on read
  and an enable mask that feeds a summary bit of the status byte.
  Assumes commands arrive one per cycle from a parser on the same clock and
  that the instrument state inputs come from outside this clock domain.
*/
// What this block does
// RULE1: Operation bits: 14,12,11,10,9,8,6,5 used
// RULE2: Status bit 7 ORs enabled operation events
// RULE3: Operation mask writable, query returns it unchanged
// RULE4: Operation events latch; read returns then clears
// RULE5: Questionable condition is live, not latched
// RULE6: Preset loads masks with 8193 and 255
// RULE7: Questionable events latch; read returns then clears
// RULE8: Only bits 13 and 12 latch questionable
// RULE9: Questionable bits: 14,13,12,6,3,1,0 used
// RULE10: Mode error bits 1 and 0 both allowed
// RULE11: Status bit 3 ORs enabled questionable events
// RULE12: Questionable mask writable and readable back
// RULE13: Mask bit one enables, zero disables
// RULE14: Operation condition is live, not latched
// RULE15: Operation event sets on rise, held until read
`timescale 1ns/1ps
module isr_status (
  // Clock and reset
  input  wire logic                       MCLK,
  input  wire logic                       RST_N,
  // Live instrument states
  input  wire isr_pkg::isr_oper_cond_type OPER_STATE,
  input  wire isr_pkg::isr_ques_cond_type QUES_STATE,
  // Command port from the parser
  input  wire isr_pkg::isr_cmd_type       CMD,
  // Answer port
  output logic                            RSP_VALID,
  output logic                            RSP_ERROR,
  output logic [isr_pkg::REG_W-1:0]       RSP_DATA,
  // Status byte summary bits
  output logic                            STB_OPER_SUMMARY,
  output logic                            STB_QUES_SUMMARY
);
  import isr_pkg::*;

  localparam int unsigned OPER_N = $bits(isr_oper_cond_type);
  localparam int unsigned QUES_N = $bits(isr_ques_cond_type);

  // Whole state of the block
  typedef struct packed {
    logic [REG_W-1:0] oper_prev;
    logic [REG_W-1:0] ques_prev;
    logic [REG_W-1:0] oper_event;
    logic [REG_W-1:0] ques_event;
    logic [REG_W-1:0] oper_enable;
    logic [REG_W-1:0] ques_enable;
    logic             rsp_valid;
    logic             rsp_error;
    logic [REG_W-1:0] rsp_data;
    logic             oper_summary;
    logic             ques_summary;
  } isr_state_type;

  isr_state_type     state_q;
  isr_state_type     state_d;

  isr_oper_cond_type oper_sync;
  isr_ques_cond_type ques_sync;
  logic [REG_W-1:0]  oper_cond;
  logic [REG_W-1:0]  ques_cond;
  logic [REG_W-1:0]  oper_rise;
  logic [REG_W-1:0]  ques_rise;
  logic              oper_event_rd;
  logic              ques_event_rd;

  // States come from other logic; bring them in through two flops
  isr_sync #(
    .WIDTH (OPER_N)
  ) u_oper_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .din   (OPER_STATE),
    .dout  (oper_sync)
  );

  isr_sync #(
    .WIDTH (QUES_N)
  ) u_ques_sync (
    .clk   (MCLK),
    .rst_n (RST_N),
    .din   (QUES_STATE),
    .dout  (ques_sync)
  );

  // Place operation states at their bit positions, unused bits zero
  always_comb begin
    oper_cond                               = '0; // RULE1
    oper_cond[OPER_LIST_RUNNING_BIT]        = oper_sync.list_running; // RULE1
    oper_cond[OPER_LIST_COMPLETE_BIT]       = oper_sync.list_complete;
    oper_cond[OPER_SAMPLE_COMPLETE_BIT]     = oper_sync.sample_complete;
    oper_cond[OPER_CONSTANT_CURRENT_BIT]    = oper_sync.constant_current;
    oper_cond[OPER_TRANSIENT_COMPLETE_BIT]  = oper_sync.transient_complete;
    oper_cond[OPER_CONSTANT_VOLTAGE_BIT]    = oper_sync.constant_voltage;
    oper_cond[OPER_TRANSIENT_ARMED_BIT]     = oper_sync.transient_armed;
    oper_cond[OPER_WAITING_FOR_TRIGGER_BIT] = oper_sync.waiting_for_trigger;
  end

  // Place questionable conditions; both mode error bits may show at once
  always_comb begin
    ques_cond                              = '0; // RULE9
    ques_cond[QUES_SINKING_ENERGY_BIT]     = ques_sync.sinking_energy; // RULE9
    ques_cond[QUES_CURRENT_ERROR_BIT]      = ques_sync.current_error;
    ques_cond[QUES_VOLTAGE_ERROR_BIT]      = ques_sync.voltage_error;
    ques_cond[QUES_SLAVE_ERROR_BIT]        = ques_sync.slave_error;
    ques_cond[QUES_THERMAL_ERROR_BIT]      = ques_sync.thermal_error;
    ques_cond[QUES_CURRENT_MODE_ERROR_BIT] = ques_sync.current_mode_error; // RULE10
    ques_cond[QUES_VOLTAGE_MODE_ERROR_BIT] = ques_sync.voltage_mode_error; // RULE10
  end

  // Rising edges of conditions become events
  assign oper_rise = oper_cond & ~state_q.oper_prev; // RULE15
  // Mode errors settle transiently, so only current and voltage error latch
  assign ques_rise = ques_cond & ~state_q.ques_prev & QUES_LATCH_MASK; // RULE8

  // Read strobes of the clear-on-read registers
  assign oper_event_rd = CMD.valid && (CMD.code == CMD_OPER_EVENT_QUERY);
  assign ques_event_rd = CMD.valid && (CMD.code == CMD_QUES_EVENT_QUERY);

  // Next state: edge tracking, event latching, command decode, summaries
  always_comb begin
    state_d           = state_q;
    state_d.oper_prev = oper_cond;
    state_d.ques_prev = ques_cond;
    state_d.rsp_valid = 1'b0;
    state_d.rsp_error = 1'b0;

    // Event registers: a new event in the read cycle survives the clear
    if (oper_event_rd) begin
      state_d.oper_event = oper_rise; // RULE4
    end else begin
      state_d.oper_event = state_q.oper_event | oper_rise; // RULE15
    end
    if (ques_event_rd) begin
      state_d.ques_event = ques_rise; // RULE7
    end else begin
      state_d.ques_event = state_q.ques_event | ques_rise; // RULE7
    end

    // Command decode; every command gets one answer cycle
    if (CMD.valid) begin
      state_d.rsp_valid = 1'b1;
      state_d.rsp_data  = '0;
      case (CMD.code)
        CMD_OPER_COND_QUERY: begin
          state_d.rsp_data = oper_cond; // RULE14
        end
        CMD_OPER_ENABLE_SET: begin
          state_d.oper_enable = CMD.data; // RULE3
        end
        CMD_OPER_ENABLE_QUERY: begin
          state_d.rsp_data = state_q.oper_enable; // RULE3
        end
        CMD_OPER_EVENT_QUERY: begin
          state_d.rsp_data = state_q.oper_event; // RULE4
        end
        CMD_PRESET: begin
          state_d.oper_enable = OPER_ENABLE_PRESET; // RULE6
          state_d.ques_enable = QUES_ENABLE_PRESET; // RULE6
        end
        CMD_QUES_EVENT_QUERY: begin
          state_d.rsp_data = state_q.ques_event; // RULE7
        end
        CMD_QUES_COND_QUERY: begin
          state_d.rsp_data = ques_cond; // RULE5
        end
        CMD_QUES_ENABLE_SET: begin
          state_d.ques_enable = CMD.data; // RULE12
        end
        CMD_QUES_ENABLE_QUERY: begin
          state_d.rsp_data = state_q.ques_enable; // RULE12
        end
        default: begin
          state_d.rsp_error = 1'b1;
        end
      endcase
    end

    // Summaries follow the next event and mask values with no extra lag
    state_d.oper_summary = |(state_d.oper_event & state_d.oper_enable); // RULE2 RULE13
    state_d.ques_summary = |(state_d.ques_event & state_d.ques_enable); // RULE11 RULE13
  end

  // State register; masks start cleared so nothing reports until enabled
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q              <= '0;
      state_q.oper_enable  <= OPER_ENABLE_RESET;
      state_q.ques_enable  <= QUES_ENABLE_RESET;
      state_q.oper_event   <= EVENT_RESET;
      state_q.ques_event   <= EVENT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flops
  assign RSP_VALID        = state_q.rsp_valid;
  assign RSP_ERROR        = state_q.rsp_error;
  assign RSP_DATA         = state_q.rsp_data;
  assign STB_OPER_SUMMARY = state_q.oper_summary;
  assign STB_QUES_SUMMARY = state_q.ques_summary;

endmodule : isr_status

// [design/isr_pkg.sv]
/*
  Shared constants and types for the instrument status reporting block:
  bit positions of the operation and questionable registers, reset and
  preset values, command codes and the carriers that group related signals.
  Assumes one clock domain and that every file imports this package.
*/
package isr_pkg;

  // Register width
  localparam int unsigned REG_W = 16;

  // Operation register bit positions
  localparam int unsigned OPER_LIST_RUNNING_BIT        = 14;
  localparam int unsigned OPER_LIST_COMPLETE_BIT       = 12;
  localparam int unsigned OPER_SAMPLE_COMPLETE_BIT     = 11;
  localparam int unsigned OPER_CONSTANT_CURRENT_BIT    = 10;
  localparam int unsigned OPER_TRANSIENT_COMPLETE_BIT  = 9;
  localparam int unsigned OPER_CONSTANT_VOLTAGE_BIT    = 8;
  localparam int unsigned OPER_TRANSIENT_ARMED_BIT     = 6;
  localparam int unsigned OPER_WAITING_FOR_TRIGGER_BIT = 5;

  // Questionable register bit positions
  localparam int unsigned QUES_SINKING_ENERGY_BIT      = 14;
  localparam int unsigned QUES_CURRENT_ERROR_BIT       = 13;
  localparam int unsigned QUES_VOLTAGE_ERROR_BIT       = 12;
  localparam int unsigned QUES_SLAVE_ERROR_BIT         = 6;
  localparam int unsigned QUES_THERMAL_ERROR_BIT       = 3;
  localparam int unsigned QUES_CURRENT_MODE_ERROR_BIT  = 1;
  localparam int unsigned QUES_VOLTAGE_MODE_ERROR_BIT  = 0;

  // Bits that may latch into the questionable event register
  localparam logic [REG_W-1:0] QUES_LATCH_MASK = 16'h3000;

  // Values after reset
  localparam logic [REG_W-1:0] OPER_ENABLE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] QUES_ENABLE_RESET = 16'h0000;
  localparam logic [REG_W-1:0] EVENT_RESET       = 16'h0000;

  // Values loaded by the preset command (8193 and 255)
  localparam logic [REG_W-1:0] OPER_ENABLE_PRESET = 16'h2001;
  localparam logic [REG_W-1:0] QUES_ENABLE_PRESET = 16'h00FF;

  // Synchroniser depth in cycles
  localparam int unsigned SYNC_STAGES = 2;

  // Status commands and queries
  typedef enum logic [3:0] {
    CMD_OPER_COND_QUERY,
    CMD_OPER_ENABLE_SET,
    CMD_OPER_ENABLE_QUERY,
    CMD_OPER_EVENT_QUERY,
    CMD_PRESET,
    CMD_QUES_EVENT_QUERY,
    CMD_QUES_COND_QUERY,
    CMD_QUES_ENABLE_SET,
    CMD_QUES_ENABLE_QUERY
  } isr_cmd_code_type;

  // One command from the parser
  typedef struct packed {
    logic             valid;
    isr_cmd_code_type code;
    logic [REG_W-1:0] data;
  } isr_cmd_type;

  // Live operating states
  typedef struct packed {
    logic list_running;
    logic list_complete;
    logic sample_complete;
    logic constant_current;
    logic transient_complete;
    logic constant_voltage;
    logic transient_armed;
    logic waiting_for_trigger;
  } isr_oper_cond_type;

  // Live questionable conditions
  typedef struct packed {
    logic sinking_energy;
    logic current_error;
    logic voltage_error;
    logic slave_error;
    logic thermal_error;
    logic current_mode_error;
    logic voltage_mode_error;
  } isr_ques_cond_type;

endpackage : isr_pkg

// [design/isr_sync.sv]
/*
  Two-stage synchroniser for a group of level signals.
  Assumes the inputs are quasi-static levels; words are not kept coherent
  across bits, which is fine for independent status flags.
*/
`timescale 1ns/1ps
module isr_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import isr_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } isr_sync_state_type;

  isr_sync_state_type state_q;
  isr_sync_state_type state_d;

  // First stage feeds only the second
  always_comb begin
    state_d        = state_q;
    state_d.meta   = din;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign dout = state_q.stable;

endmodule : isr_sync

// [tb/isr_host_model.sv]
/*
  Remote host model: issues one status command at a time and takes the answer.
  Assumes the block answers at the taking edge, so the answer is there by the next falling edge.
*/
`timescale 1ns/1ps
module isr_host_model (
  // Clock
  input  wire logic                   MCLK,
  // Command and answer
  output isr_pkg::isr_cmd_type        CMD,
  input  wire logic                   RSP_VALID,
  input  wire logic                   RSP_ERROR,
  input  wire logic [isr_pkg::REG_W-1:0] RSP_DATA
);
  import isr_pkg::*;
  initial CMD = '0;
  // Drive at the falling edge, take the answer one cycle later
  task automatic issue(input isr_cmd_code_type c, input logic [REG_W-1:0] d,
                       output logic [REG_W-1:0] rd, output logic er);
    @(negedge MCLK);
    CMD = {1'b1, c, d};
    @(negedge MCLK);
    rd = RSP_VALID ? RSP_DATA : ~RSP_DATA; // Missing answer shows as a wrong word
    er = RSP_ERROR;
    CMD = {1'b0, c, ~d}; // Released data bus never keeps a stale word
  endtask : issue
endmodule : isr_host_model

// [tb/isr_status_props.sv]
/*
  Checker for the status register bank, bound to its top module.
  Assumes the masks reset to zero and one clock domain.
*/
`timescale 1ns/1ps
module isr_status_props (
  // Clock and reset
  input wire logic                       MCLK,
  input wire logic                       RST_N,
  // Observed ports
  input wire isr_pkg::isr_oper_cond_type OPER_STATE,
  input wire isr_pkg::isr_ques_cond_type QUES_STATE,
  input wire isr_pkg::isr_cmd_type       CMD,
  input wire logic                       RSP_VALID,
  input wire logic                       RSP_ERROR,
  input wire logic [isr_pkg::REG_W-1:0]  RSP_DATA,
  input wire logic                       STB_OPER_SUMMARY,
  input wire logic                       STB_QUES_SUMMARY
);
  import isr_pkg::*;
  logic [REG_W-1:0] om_q;
  logic [REG_W-1:0] qm_q;
  // Mirror of both masks, so query answers can be judged
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      om_q <= '0;
      qm_q <= '0;
    end else if (CMD.valid) begin
      case (CMD.code)
        CMD_OPER_ENABLE_SET: om_q <= CMD.data;
        CMD_QUES_ENABLE_SET: qm_q <= CMD.data;
        CMD_PRESET: begin
          om_q <= 16'h2001;
          qm_q <= 16'h00FF;
        end
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  AST_ANSWER_NEXT: assert property (CMD.valid |=> RSP_VALID)
    else $error("no answer after command");
  AST_ANSWER_CAUSE: assert property (RSP_VALID |-> $past(CMD.valid))
    else $error("answer without command");
  AST_OPER_MASK_BACK: assert property (CMD.valid && CMD.code == CMD_OPER_ENABLE_QUERY |=> RSP_DATA == om_q)
    else $error("operation mask readback wrong");
  AST_QUES_MASK_BACK: assert property (CMD.valid && CMD.code == CMD_QUES_ENABLE_QUERY |=> RSP_DATA == qm_q)
    else $error("questionable mask readback wrong");
  AST_OPER_UNUSED: assert property (CMD.valid && CMD.code == CMD_OPER_COND_QUERY |=> (RSP_DATA & 16'hA09F) == '0)
    else $error("operation unused bit set");
  AST_QUES_UNUSED: assert property (CMD.valid && CMD.code == CMD_QUES_COND_QUERY |=> (RSP_DATA & 16'h8FB4) == '0)
    else $error("questionable unused bit set");
  AST_QUES_LATCH: assert property (CMD.valid && CMD.code == CMD_QUES_EVENT_QUERY |=> (RSP_DATA & 16'hCFFF) == '0)
    else $error("questionable event outside bits 13 and 12");
  AST_OPER_SUM: assert property (RSP_VALID && $past(CMD.code) == CMD_OPER_EVENT_QUERY &&
    (RSP_DATA & om_q) != '0 |-> $past(STB_OPER_SUMMARY))
    else $error("operation summary low with enabled event");
  AST_QUES_SUM: assert property (RSP_VALID && $past(CMD.code) == CMD_QUES_EVENT_QUERY &&
    (RSP_DATA & qm_q) != '0 |-> $past(STB_QUES_SUMMARY))
    else $error("questionable summary low with enabled event");
  AST_MASK_OFF: assert property (om_q == '0 && qm_q == '0 |-> !STB_OPER_SUMMARY && !STB_QUES_SUMMARY)
    else $error("summary set with masks cleared");
  COV_ERROR: cover property (RSP_ERROR);
  COV_OPER_SUM: cover property (STB_OPER_SUMMARY);
  COV_QUES_SUM: cover property (STB_QUES_SUMMARY);
endmodule : isr_status_props

bind isr_status isr_status_props u_props (.MCLK(MCLK), .RST_N(RST_N), .OPER_STATE(OPER_STATE),
  .QUES_STATE(QUES_STATE), .CMD(CMD), .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .RSP_DATA(RSP_DATA),
  .STB_OPER_SUMMARY(STB_OPER_SUMMARY), .STB_QUES_SUMMARY(STB_QUES_SUMMARY));

// [tb/isr_status_tb.sv]
/*
  Self-checking bench for the status register bank.
  Assumes the host model answers in one cycle; inputs change at falling edges.
*/
`timescale 1ns/1ps
module isr_status_tb;
  import isr_pkg::*;
  logic              MCLK;
  logic              RST_N;
  isr_oper_cond_type oper;
  isr_ques_cond_type ques;
  isr_cmd_type       cmd_w;
  logic              rsp_v;
  logic              rsp_e;
  logic [REG_W-1:0]  rsp_d;
  logic              s_op;
  logic              s_qs;
  int                mismatches;
  int                checks_done;
  isr_status DUT (.MCLK(MCLK), .RST_N(RST_N), .OPER_STATE(oper), .QUES_STATE(ques), .CMD(cmd_w),
    .RSP_VALID(rsp_v), .RSP_ERROR(rsp_e), .RSP_DATA(rsp_d), .STB_OPER_SUMMARY(s_op), .STB_QUES_SUMMARY(s_qs));
  isr_host_model host (.MCLK(MCLK), .CMD(cmd_w), .RSP_VALID(rsp_v), .RSP_ERROR(rsp_e), .RSP_DATA(rsp_d));
  // Shared comparison
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input isr_cmd_code_type c, input logic [15:0] d, input logic [15:0] e);
    logic [15:0] rd;
    logic        er;
    host.issue(c, d, rd, er);
    chk(c.name(), e, rd);
  endtask : run
  // Two flops of sync plus the latch, with margin
  task automatic settle;
    repeat (5) @(negedge MCLK);
  endtask : settle
  task automatic t_masks;
    logic [15:0] rd;
    logic        er;
    run(CMD_OPER_ENABLE_SET, 16'hA5C3, 16'h0000);
    run(CMD_OPER_ENABLE_QUERY, 16'h0000, 16'hA5C3);
    run(CMD_QUES_ENABLE_SET, 16'h5A3C, 16'h0000);
    run(CMD_QUES_ENABLE_QUERY, 16'h0000, 16'h5A3C);
    run(CMD_PRESET, 16'h0000, 16'h0000);
    run(CMD_OPER_ENABLE_QUERY, 16'h0000, 16'h2001);
    run(CMD_QUES_ENABLE_QUERY, 16'h0000, 16'h00FF);
    // Unknown code must change nothing
    host.issue(isr_cmd_code_type'(4'hF), 16'h1234, rd, er);
    chk("unknown_error", 16'h0001, {15'h0000, er});
    chk("unknown_data", 16'h0000, rd);
    run(CMD_QUES_ENABLE_QUERY, 16'h0000, 16'h00FF);
  endtask : t_masks
  task automatic t_enable;
    run(CMD_OPER_ENABLE_SET, 16'hFBFF, 16'h0000);
    oper.constant_current = 1'b1;
    settle();
    chk("oper_summary", 16'h0000, {15'h0000, s_op});
    run(CMD_OPER_ENABLE_SET, 16'h0400, 16'h0000);
    chk("oper_summary", 16'h0001, {15'h0000, s_op});
    run(CMD_OPER_EVENT_QUERY, 16'h0000, 16'h0400);
    oper = '0;
    settle();
    // Rise reaching the latch in the read cycle must survive the clear
    oper.list_running = 1'b1;
    @(negedge MCLK);
    run(CMD_OPER_EVENT_QUERY, 16'h0000, 16'h0000);
    run(CMD_OPER_EVENT_QUERY, 16'h0000, 16'h4000);
    oper = '0;
    settle();
  endtask : t_enable
  // Each operation state in turn: live condition, rise event, clear on read
  task automatic t_oper;
    int          pos [8] = '{5, 6, 8, 9, 10, 11, 12, 14};
    logic [15:0] b;
    for (int i = 0; i < 8; i++) begin
      b = 16'h0001 << pos[i];
      run(CMD_OPER_ENABLE_SET, b, 16'h0000);
      oper[i] = 1'b1;
      settle();
      run(CMD_OPER_COND_QUERY, 16'h0000, b);
      chk("oper_summary", 16'h0001, {15'h0000, s_op});
      run(CMD_OPER_EVENT_QUERY, 16'h0000, b);
      run(CMD_OPER_EVENT_QUERY, 16'h0000, 16'h0000);
      chk("oper_summary", 16'h0000, {15'h0000, s_op});
      oper[i] = 1'b0;
      settle();
      run(CMD_OPER_COND_QUERY, 16'h0000, 16'h0000);
      run(CMD_OPER_EVENT_QUERY, 16'h0000, 16'h0000);
    end
  endtask : t_oper
  // Each questionable state: only bits 13 and 12 may latch
  task automatic t_ques;
    int          pos [7] = '{0, 1, 3, 6, 12, 13, 14};
    logic [15:0] b;
    logic [15:0] e;
    run(CMD_QUES_ENABLE_SET, 16'hFFFF, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      b = 16'h0001 << pos[i];
      e = b & 16'h3000;
      ques[i] = 1'b1;
      settle();
      run(CMD_QUES_COND_QUERY, 16'h0000, b);
      chk("ques_summary", {15'h0000, |e}, {15'h0000, s_qs});
      run(CMD_QUES_EVENT_QUERY, 16'h0000, e);
      run(CMD_QUES_EVENT_QUERY, 16'h0000, 16'h0000);
      ques[i] = 1'b0;
      settle();
      run(CMD_QUES_COND_QUERY, 16'h0000, 16'h0000);
    end
    ques = 7'h03;
    settle();
    run(CMD_QUES_COND_QUERY, 16'h0000, 16'h0003);
    ques = '0;
  endtask : t_ques
  // Verdict, reached from the main sequence or the watchdog
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // Whole run is well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
  initial begin
    RST_N = 1'b0;
    oper = '0;
    ques = '0;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(negedge MCLK);
    RST_N = 1'b1;
    t_masks();
    t_enable();
    t_oper();
    t_ques();
    close_out();
  end
endmodule : isr_status_tb
